// *** far_side_model.sv ***
// Far-side model: DRAM array and the four node global memories.
// Assumes the block's clock; released lines never hold their last value.
`timescale 1ns/100ps
module far_side_model
(
  // Clock
  input wire logic clk,
  // DRAM pins
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [13:0] addr,
  input wire logic [31:0] dq_o,
  output logic [31:0] dq_i,
  // Node ports
  input wire logic [3:0] req,
  input wire logic [31:0] gaddr,
  output logic [127:0] grdata,
  output logic [3:0] done = 4'h0
);
  logic [31:0] mem_reg [64];
  logic [1:0] row_reg = 2'h0;
  logic [31:0] junk_reg = 32'h0;
  logic [3:0] req_d_reg = 4'h0;
  wire rd_on = !ras_n && !cas_n && we_n;
  // Two row bits in the key catch page aliasing
  assign dq_i = rd_on ? mem_reg[{row_reg, addr[3:0]}] : ~junk_reg;
  always_ff @(posedge clk)
  begin
    junk_reg <= junk_reg + 32'h0101_0101;
    if (ras_n)
      row_reg <= addr[1:0];
    if (!ras_n && !cas_n && !we_n)
      mem_reg[{row_reg, addr[3:0]}] <= dq_o;
    req_d_reg <= req;
    done <= req & req_d_reg;
  end
  for (genvar n = 0; n < 4; n++)
  begin : g_node
    assign grdata[32*n+:32] = done[n] ? gaddr ^ {4'(n + 1), 28'h0} : ~junk_reg;
  end
endmodule

// *** memtgt_pkg.sv ***
// Constants shared by the shared-bus memory target logic.
// Assumes a 10 MHz system clock; the refresh, load and programming cycle counts are derived from it here.
package memtgt_pkg;

  // Clock and derived timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int REFR_PERIOD_NS = 14000;
  localparam int REFR_PERIOD_CYC = REFR_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REFR_BUSY_NS = 240;
  localparam int REFR_BUSY_CYC = (REFR_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_WIN_NS = 150000;
  localparam int LOAD_WIN_CYC = LOAD_WIN_NS / CLK_PERIOD_NS;
  localparam int PROG_TIME_NS = 10000000;
  localparam int PROG_TIME_CYC = PROG_TIME_NS / CLK_PERIOD_NS;

  // Wait states after grant, refresh count load and miss strobe timing
  localparam logic [2:0] DRAM_WS_HIT = 3'h1;
  localparam logic [2:0] DRAM_WS_MISS = 3'h4;
  localparam logic [2:0] BOOT_WS = 3'h5;
  localparam logic [2:0] REFR_CNT_LOAD = 3'(REFR_BUSY_CYC - 1);
  localparam logic [2:0] MISS_RAS_AT = 3'h2;
  localparam logic [2:0] MISS_CAS_AT = 3'h1;

  // DRAM fit options and geometry
  localparam logic [1:0] DRAM_NONE = 2'h0;
  localparam logic [1:0] DRAM_4M = 2'h1;
  localparam logic [1:0] DRAM_16M = 2'h2;
  localparam int DRAM_COL_W = 10;
  localparam int DRAM_ROW_W = 14;

  // Master identities
  localparam logic [2:0] M_VME = 3'h0;
  localparam logic [2:0] M_EXP = 3'h1;
  localparam logic [2:0] M_NODE_A = 3'h2;
  localparam logic [2:0] M_NODE_D = 3'h5;

  // Address bases (longword offsets unless noted)
  localparam logic [31:0] NODE_MASTER_BASE = 32'h8000_0000;
  localparam logic [31:0] VME_BASE_DEFAULT = 32'h1000_0000;
  localparam logic [31:0] EXP_BASE_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] GM_TARGET_BASE = 32'h8000_0000;
  localparam logic [31:0] NODE_REGION_FIRST = 32'h0888_0000;
  localparam logic [31:0] NODE_REGION_STEP = 32'h0008_0000;
  localparam logic [31:0] NODE_WIN_BASE = NODE_REGION_FIRST - NODE_REGION_STEP;
  localparam int NODE_MASK_LSB = 19;
  localparam int NODE_WIN_LSB = 23;
  localparam logic [31:0] BOOT_BASE = 32'h0800_0000;
  localparam logic [31:0] DRAM_BASE = 32'h0900_0000;
  localparam logic [31:0] VME_LW_ORIGIN = 32'h0800_0000;

  // Boot memory
  localparam int BOOT_AW = 17;
  localparam int PAGE_AW = 7;
  localparam int PAGE_BYTES = 128;
  localparam logic [7:0] BYTE_ERASED = 8'hff;
  localparam int POLL_BIT = 7;
  localparam logic [16:0] CMD_ADDR1 = 17'h05555;
  localparam logic [16:0] CMD_ADDR2 = 17'h02aaa;
  localparam logic [7:0] CMD_D1 = 8'haa;
  localparam logic [7:0] CMD_D2 = 8'h55;
  localparam logic [7:0] CMD_ENABLE = 8'ha0;
  localparam logic [7:0] CMD_DIS_PREFIX = 8'h80;
  localparam logic [7:0] CMD_DISABLE = 8'h20;

  typedef enum logic [1:0] {S_IDLE = 2'b00, S_BUSY = 2'b01, S_DONE = 2'b11,
    S_REFR = 2'b10} state_t;
  typedef enum logic [1:0] {T_DRAM = 2'b00, T_BOOT = 2'b01, T_NODE = 2'b11} target_t;

endpackage

// *** pin_sync3.sv ***
// Three-stage input synchroniser for one pin-level signal.
// Assumes the input is a slow level from outside the clock domain.
`timescale 1ns/100ps
module pin_sync3
  import memtgt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic q_reg;

  // First stage feeds the second stage only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        q_reg <= s3_reg;
    end
  end

  assign q = q_reg;
endmodule

// *** pulse_divider.sv ***
// Divider giving a one-cycle enable pulse every PERIOD clocks.
// Assumes a single clock; en low holds the count at zero.
`timescale 1ns/100ps
module pulse_divider
  import memtgt_pkg::*;
#(
  parameter int PERIOD = 140
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control and tick
  input wire logic en,
  output logic tick
);
  localparam int W = $clog2(PERIOD);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);
  logic [W-1:0] cnt_reg;
  logic tick_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n || !en)
    begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (cnt_reg == LAST)
    begin
      cnt_reg <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  assign tick = tick_reg;
endmodule

// *** shared_bus_memory_targets.sv ***
// Shared-bus slave serving shared DRAM, the boot flash memory and node windows.
// Assumes the arbiter presents only the granted master on the sb_* port.
//
// How it works
// RULE_01: DRAM fitted absent, 4M or 16M words
// RULE_02: Fast page mode, 1024-word pages
// RULE_03: One wait in page, four across pages
// RULE_04: Self-refresh every 14 us, 240 ns long
// RULE_05: Boot memory 128K, low byte lanes only
// RULE_06: Five wait states per boot memory access
// RULE_07: Master idles two instructions after boot reads
// RULE_08: Master idles two instructions between read, write
// RULE_09: Protected programming needs three-write command prefix
// RULE_10: Protection persists; only disable sequence clears it
// RULE_11: 128-byte pages; unloaded bytes become FFh
// RULE_12: Master loads page bytes within 150 us
// RULE_13: Polled last byte shows inverted bit 7
// RULE_14: Node window start maps to 8000_0000h
// RULE_15: Multi-node windows write-only, broadcast same offset
// RULE_16: Windows from 0888_0000h, step 0008_0000h, mask
// RULE_17: Node may not reach its own memory
// RULE_18: Absent node memory ends in bus error
// RULE_19: Offsets relative to per-master-type base
// RULE_20: Refresh holds off pending DRAM access
// RULE_21: Wait states counted from granted request
`timescale 1ns/100ps
module shared_bus_memory_targets
  import memtgt_pkg::*;
#(
  parameter logic [1:0] DRAM_SIZE = DRAM_16M,
  parameter logic [31:0] vme_window_base = VME_BASE_DEFAULT,
  parameter logic [31:0] EXP_BASE = EXP_BASE_DEFAULT,
  parameter int PROG_CYC = PROG_TIME_CYC,
  parameter int LOAD_CYC = LOAD_WIN_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Shared bus, granted master
  input wire logic sb_req,
  input wire logic sb_we,
  input wire logic [2:0] sb_master,
  input wire logic [31:0] sb_addr,
  input wire logic [31:0] sb_wdata,
  output logic sb_ack,
  output logic sb_err,
  output logic [31:0] sb_rdata,
  // DRAM pins
  output logic dram_ras_n,
  output logic dram_cas_n,
  output logic dram_we_n,
  output logic [DRAM_ROW_W-1:0] dram_addr,
  output logic [31:0] dram_dq_o,
  output logic dram_dq_oe,
  input wire logic [31:0] dram_dq_i,
  // Node global memory ports
  output logic [3:0] gm_req,
  output logic gm_we,
  output logic [31:0] gm_addr,
  output logic [31:0] gm_wdata,
  input wire logic [127:0] gm_rdata,
  input wire logic [3:0] gm_done,
  input wire logic [3:0] gm_fitted
);
  localparam logic [16:0] PROG_LOAD = 17'(PROG_CYC - 1);
  localparam logic [10:0] WIN_LOAD = 11'(LOAD_CYC - 1);

  state_t state_reg;
  target_t kind_reg;
  logic [2:0] cnt_reg;
  logic sb_ack_reg, sb_err_reg, refr_pend_reg, we_reg, miss_reg;
  logic [31:0] sb_rdata_reg;
  logic ras_n_reg, cas_n_reg, we_n_reg, dq_oe_reg, page_open_reg;
  logic [DRAM_ROW_W-1:0] addr_reg, row_reg;
  logic [DRAM_COL_W-1:0] col_reg;
  logic [31:0] dq_o_reg;
  logic [3:0] gm_req_reg;
  logic gm_we_reg;
  logic [31:0] gm_addr_reg, gm_wdata_reg;
  logic [1:0] sel_reg;
  logic prot_reg, armed_reg, loading_reg, busy_reg;
  logic [2:0] seq_reg;
  logic [10:0] win_reg;
  logic [16:0] prog_reg;
  logic [7:0] idx_reg, last_reg;
  logic [BOOT_AW-PAGE_AW-1:0] pg_base_reg;
  logic [PAGE_BYTES-1:0] loaded_reg;
  logic [BOOT_AW-1:0] baddr_reg;
  logic [7:0] boot_mem [0:(1<<BOOT_AW)-1];
  logic [7:0] page_buf [0:PAGE_BYTES-1];
  logic [3:0] done_s, fitted_s;
  logic refr_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and refresh divider

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      pin_sync3 u_done (.clk(clk), .rst_n(rst_n), .d(gm_done[gi]), .q(done_s[gi]));
      pin_sync3 u_fit (.clk(clk), .rst_n(rst_n), .d(gm_fitted[gi]), .q(fitted_s[gi]));
    end
  endgenerate

  pulse_divider #(.PERIOD(REFR_PERIOD_CYC)) u_refr (
    .clk(clk),
    .rst_n(rst_n),
    .en(DRAM_SIZE != DRAM_NONE),
    .tick(refr_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address normalisation and decode

  wire [31:0] vme_diff = sb_addr - vme_window_base;
  wire is_vme = sb_master == M_VME;
  wire is_exp = sb_master == M_EXP;
  wire is_node_m = sb_master >= M_NODE_A && sb_master <= M_NODE_D;
  // VME offsets are bytes, everyone else counts longwords
  wire [31:0] off_w = is_vme ? {2'b00, vme_diff[31:2]} + VME_LW_ORIGIN : // [RULE_19]
    is_exp ? sb_addr - EXP_BASE : sb_addr - NODE_MASTER_BASE;
  wire [1:0] req_node = 2'(sb_master - M_NODE_A);
  wire [3:0] own_mask = is_node_m ? 4'h1 << req_node : 4'h0;

  wire hit_boot = off_w[31:BOOT_AW] == BOOT_BASE[31:BOOT_AW];
  wire dram_fits = DRAM_SIZE == DRAM_16M || off_w[23:22] == 2'h0;
  wire hit_dram = DRAM_SIZE != DRAM_NONE && off_w[31:24] == DRAM_BASE[31:24]
    && dram_fits;                                                 // [RULE_01]
  wire [3:0] node_mask = off_w[NODE_WIN_LSB-1:NODE_MASK_LSB];
  wire hit_node = off_w[31:NODE_WIN_LSB] == NODE_WIN_BASE[31:NODE_WIN_LSB]
    && node_mask != 4'h0;                                         // [RULE_16]
  wire node_multi = (node_mask & (node_mask - 4'h1)) != 4'h0;
  wire node_self = (node_mask & own_mask) != 4'h0;                // [RULE_17]
  wire node_absent = (node_mask & ~fitted_s) != 4'h0;             // [RULE_18]
  wire node_rd_multi = node_multi && !sb_we;                      // [RULE_15]
  wire node_bad = node_self || node_absent || node_rd_multi;
  wire bad = !(hit_boot || hit_dram || hit_node) || (hit_node && node_bad);
  // Four-phase handshake: wait for earlier done to fall first
  wire node_stall = hit_node && !node_bad && (node_mask & done_s) != 4'h0;
  wire [DRAM_ROW_W-1:0] dram_row = off_w[DRAM_COL_W+DRAM_ROW_W-1:DRAM_COL_W];
  wire [DRAM_COL_W-1:0] dram_col = off_w[DRAM_COL_W-1:0];
  wire page_hit = page_open_reg && row_reg == dram_row;           // [RULE_02]
  wire [2:0] ws = hit_boot ? BOOT_WS : page_hit ? DRAM_WS_HIT : DRAM_WS_MISS;

  wire start_refr = state_reg == S_IDLE && refr_pend_reg;
  wire take = state_reg == S_IDLE && sb_req && !refr_pend_reg && !node_stall; // [RULE_20]
  wire take_ok = take && !bad;
  wire fin = state_reg == S_BUSY &&
    (kind_reg == T_NODE ? (gm_req_reg & ~done_s) == 4'h0 : cnt_reg == 3'h0);
  wire [31:0] node_rd = gm_rdata[sel_reg*32 +: 32];
  wire [7:0] boot_rd = busy_reg ?                                 // [RULE_13]
    {~last_reg[POLL_BIT], last_reg[POLL_BIT-1:0]} : boot_mem[baddr_reg];

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= S_IDLE;
      kind_reg <= T_DRAM;
      cnt_reg <= 3'h0;
      sb_ack_reg <= 1'b0;
      sb_err_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
          if (start_refr)
          begin
            state_reg <= S_REFR;
            cnt_reg <= REFR_CNT_LOAD;                             // [RULE_04]
          end
          else if (take && bad)
          begin
            sb_err_reg <= 1'b1;
            state_reg <= S_DONE;
          end
          else if (take)
          begin
            state_reg <= S_BUSY;
            kind_reg <= hit_boot ? T_BOOT : hit_dram ? T_DRAM : T_NODE;
            cnt_reg <= ws - 3'h1;                                 // [RULE_03] [RULE_06] [RULE_21]
          end
        S_BUSY:
          if (fin)
          begin
            sb_ack_reg <= 1'b1;
            state_reg <= S_DONE;
          end
          else if (kind_reg != T_NODE)
            cnt_reg <= cnt_reg - 3'h1;
        S_DONE:
        begin
          sb_ack_reg <= 1'b0;
          sb_err_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
        default:
          if (cnt_reg == 3'h0)
            state_reg <= S_IDLE;
          else
            cnt_reg <= cnt_reg - 3'h1;
      endcase
    end
  end

  // Tick wins over the clear so no refresh is lost
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      refr_pend_reg <= 1'b0;
    else if (refr_tick)
      refr_pend_reg <= 1'b1;                                      // [RULE_04]
    else if (start_refr)
      refr_pend_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sb_rdata_reg <= 32'h0;
    else if (fin)
      sb_rdata_reg <= kind_reg == T_DRAM ? dram_dq_i :
        kind_reg == T_BOOT ? {24'h0, boot_rd} : node_rd;          // [RULE_05]
  end

  a_boot_wait: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
    take_ok && hit_boot |-> !sb_ack [*6] ##1 sb_ack)
    else $error("boot access not acked after five waits");
  a_dram_hit: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
    take_ok && hit_dram && page_hit |-> ##2 sb_ack)
    else $error("page hit not acked after one wait");
  a_dram_miss: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
    take_ok && hit_dram && !page_hit |-> !sb_ack [*5] ##1 sb_ack)
    else $error("page miss not acked after four waits");
  a_self_refused: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_17]
    take && hit_node && node_self |=> sb_err && !sb_ack)
    else $error("own node access not refused");
  a_bcast_read: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
    take && hit_node && node_multi && !sb_we |=> sb_err)
    else $error("multi-node read not refused");
  a_absent_node: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_18]
    take && hit_node && node_absent |=> sb_err && gm_req == 4'h0)
    else $error("absent node access not errored");

  ////////////////////////////////////////////////////////////////////////////
  // DRAM strobes, fast page mode

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ras_n_reg <= 1'b1;
      cas_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
      page_open_reg <= 1'b0;
      addr_reg <= '0;
      row_reg <= '0;
      col_reg <= '0;
      dq_o_reg <= 32'h0;
      we_reg <= 1'b0;
      miss_reg <= 1'b0;
    end
    else if (start_refr)
    begin
      // CAS before RAS; the open page is lost
      ras_n_reg <= 1'b1;
      cas_n_reg <= 1'b0;
      page_open_reg <= 1'b0;
    end
    else if (state_reg == S_REFR)
    begin
      ras_n_reg <= cnt_reg == 3'h0 ? 1'b1 : 1'b0;
      cas_n_reg <= cnt_reg == 3'h0;
    end
    else if (take_ok && hit_dram)
    begin
      we_reg <= sb_we;
      col_reg <= dram_col;
      dq_o_reg <= sb_wdata;
      miss_reg <= !page_hit;
      if (page_hit)
      begin
        addr_reg <= {{(DRAM_ROW_W-DRAM_COL_W){1'b0}}, dram_col};
        cas_n_reg <= 1'b0;
        we_n_reg <= !sb_we;
        dq_oe_reg <= sb_we;
      end
      else
      begin
        ras_n_reg <= 1'b1;                                        // [RULE_02]
        addr_reg <= dram_row;
        row_reg <= dram_row;
        page_open_reg <= 1'b1;
      end
    end
    else if (state_reg == S_BUSY && kind_reg == T_DRAM)
    begin
      if (fin)
      begin
        cas_n_reg <= 1'b1;
        we_n_reg <= 1'b1;
        dq_oe_reg <= 1'b0;
      end
      else if (miss_reg && cnt_reg == MISS_RAS_AT)
        ras_n_reg <= 1'b0;
      else if (miss_reg && cnt_reg == MISS_CAS_AT)
      begin
        addr_reg <= {{(DRAM_ROW_W-DRAM_COL_W){1'b0}}, col_reg};
        cas_n_reg <= 1'b0;
        we_n_reg <= !we_reg;
        dq_oe_reg <= we_reg;
      end
    end
  end

  a_refresh_len: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
    start_refr |=> (!dram_cas_n) [*3] ##1 dram_cas_n)
    else $error("refresh did not last three cycles");
  a_refresh_period: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
    refr_tick |-> ##140 refr_tick)
    else $error("refresh period is not 140 cycles");
  a_dq_drive: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
    !dram_ras_n && !dram_cas_n |-> dram_dq_oe == !dram_we_n)
    else $error("data drive mismatch");

  ////////////////////////////////////////////////////////////////////////////
  // Node global memory forwarding

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gm_req_reg <= 4'h0;
      gm_we_reg <= 1'b0;
      gm_addr_reg <= 32'h0;
      gm_wdata_reg <= 32'h0;
      sel_reg <= 2'h0;
    end
    else if (take_ok && hit_node)
    begin
      gm_req_reg <= node_mask;                                    // [RULE_15]
      gm_we_reg <= sb_we;
      gm_addr_reg <= GM_TARGET_BASE | {13'h0, off_w[NODE_MASK_LSB-1:0]}; // [RULE_14]
      gm_wdata_reg <= sb_wdata;
      sel_reg <= node_mask[1] ? 2'h1 : node_mask[2] ? 2'h2 : node_mask[3] ? 2'h3 : 2'h0;
    end
    else if (state_reg == S_BUSY && kind_reg == T_NODE)
      gm_req_reg <= gm_req_reg & ~done_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot flash memory: protection, page load, programming

  wire boot_wr = take_ok && hit_boot && sb_we;
  wire [BOOT_AW-1:0] wa = off_w[BOOT_AW-1:0];
  wire [7:0] wb = sb_wdata[7:0];
  wire c1 = wa == CMD_ADDR1 && wb == CMD_D1;
  wire c2 = wa == CMD_ADDR2 && wb == CMD_D2;
  wire c_en = wa == CMD_ADDR1 && wb == CMD_ENABLE;
  wire c_pre = wa == CMD_ADDR1 && wb == CMD_DIS_PREFIX;
  wire c_dis = wa == CMD_ADDR1 && wb == CMD_DISABLE;
  wire is_cmd = (seq_reg == 3'h0 || seq_reg == 3'h3) ? c1 :
    (seq_reg == 3'h1 || seq_reg == 3'h4) ? c2 : seq_reg == 3'h2 ? (c_en || c_pre) : c_dis;
  wire same_page = !loading_reg || pg_base_reg == wa[BOOT_AW-1:PAGE_AW];
  wire do_load = boot_wr && !is_cmd && (!prot_reg || armed_reg) && !busy_reg
    && same_page;                                                 // [RULE_09]
  wire start_prog = loading_reg && win_reg == 11'h0 && !do_load;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prot_reg <= 1'b1;                                           // [RULE_10]
      armed_reg <= 1'b0;
      seq_reg <= 3'h0;
    end
    else if (boot_wr && !busy_reg)
    begin
      seq_reg <= (is_cmd && seq_reg != 3'h5 && !c_en) ? seq_reg + 3'h1 : 3'h0;
      if (start_prog)
        armed_reg <= 1'b0;
      if (is_cmd && seq_reg == 3'h2 && c_en)
      begin
        prot_reg <= 1'b1;
        armed_reg <= 1'b1;                                        // [RULE_09]
      end
      if (is_cmd && seq_reg == 3'h5)
        prot_reg <= 1'b0;                                         // [RULE_10]
    end
    else if (start_prog)
      armed_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      loading_reg <= 1'b0;
      busy_reg <= 1'b0;
      win_reg <= 11'h0;
      prog_reg <= 17'h0;
      idx_reg <= 8'h0;
      pg_base_reg <= '0;
      loaded_reg <= '0;
      last_reg <= 8'h0;
    end
    else if (do_load)
    begin
      loading_reg <= 1'b1;
      win_reg <= WIN_LOAD;
      pg_base_reg <= wa[BOOT_AW-1:PAGE_AW];
      loaded_reg[wa[PAGE_AW-1:0]] <= 1'b1;
      last_reg <= wb;
    end
    else if (start_prog)
    begin
      loading_reg <= 1'b0;
      busy_reg <= 1'b1;
      prog_reg <= PROG_LOAD;
      idx_reg <= 8'h0;
    end
    else if (loading_reg)
      win_reg <= win_reg - 11'h1;
    else if (busy_reg)
    begin
      idx_reg <= idx_reg[PAGE_AW] ? idx_reg : idx_reg + 8'h1;
      prog_reg <= prog_reg - 17'h1;
      if (prog_reg == 17'h0)
      begin
        busy_reg <= 1'b0;
        loaded_reg <= '0;
      end
    end
  end

  // Array and page buffer have no reset: contents are the storage itself
  always_ff @(posedge clk)
  begin
    if (do_load)
      page_buf[wa[PAGE_AW-1:0]] <= wb;
    if (busy_reg && !idx_reg[PAGE_AW])
      boot_mem[{pg_base_reg, idx_reg[PAGE_AW-1:0]}] <= loaded_reg[idx_reg[PAGE_AW-1:0]] ?
        page_buf[idx_reg[PAGE_AW-1:0]] : BYTE_ERASED;             // [RULE_11]
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      baddr_reg <= '0;
    else if (take_ok && hit_boot)
      baddr_reg <= wa;
  end

  a_poll_bit7: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
    take_ok && hit_boot && !sb_we && busy_reg && prog_reg > 17'h10
      |-> ##6 sb_rdata[POLL_BIT] != last_reg[POLL_BIT])
    else $error("poll read did not invert bit 7");

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sb_ack = sb_ack_reg;
  assign sb_err = sb_err_reg;
  assign sb_rdata = sb_rdata_reg;
  assign dram_ras_n = ras_n_reg;
  assign dram_cas_n = cas_n_reg;
  assign dram_we_n = we_n_reg;
  assign dram_addr = addr_reg;
  assign dram_dq_o = dq_o_reg;
  assign dram_dq_oe = dq_oe_reg;
  assign gm_req = gm_req_reg;
  assign gm_we = gm_we_reg;
  assign gm_addr = gm_addr_reg;
  assign gm_wdata = gm_wdata_reg;
endmodule

// *** shared_bus_memory_targets_tb.sv ***
// Self-checking bench for the shared-bus memory targets.
// Assumes far_side_model answers DRAM and node requests.
`timescale 1ns/100ps
module shared_bus_memory_targets_tb;
  import memtgt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sb_req = 1'b0;
  logic sb_we = 1'b0;
  logic [2:0] sb_master = 3'h0;
  logic [31:0] sb_addr = 32'h0;
  logic [31:0] sb_wdata = 32'h0;
  logic [3:0] gm_fitted = 4'hf;
  logic sb_ack, sb_err, ras_n, cas_n, we_n, dq_oe, gm_we;
  logic [31:0] sb_rdata, dq_o, dq_i, gm_addr, gm_wdata;
  logic [13:0] dram_addr;
  logic [3:0] gm_req, gm_done, seen;
  logic [127:0] gm_rdata;
  logic [31:0] gseen, wseen, rd;
  logic got_err, gwe;
  int cyc, errors = 0, compares = 0;
  time t0, t1;
  always #50 clk = ~clk;
  shared_bus_memory_targets #(.PROG_CYC(300), .LOAD_CYC(50)) DUT (.clk(clk), .rst_n(rst_n),
    .sb_req(sb_req), .sb_we(sb_we), .sb_master(sb_master), .sb_addr(sb_addr),
    .sb_wdata(sb_wdata), .sb_ack(sb_ack), .sb_err(sb_err), .sb_rdata(sb_rdata),
    .dram_ras_n(ras_n), .dram_cas_n(cas_n), .dram_we_n(we_n), .dram_addr(dram_addr),
    .dram_dq_o(dq_o), .dram_dq_oe(dq_oe), .dram_dq_i(dq_i), .gm_req(gm_req), .gm_we(gm_we),
    .gm_addr(gm_addr), .gm_wdata(gm_wdata), .gm_rdata(gm_rdata), .gm_done(gm_done),
    .gm_fitted(gm_fitted));
  far_side_model far (.clk(clk), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .addr(dram_addr), .dq_o(dq_o), .dq_i(dq_i), .req(gm_req), .gaddr(gm_addr),
    .grdata(gm_rdata), .done(gm_done));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access; cyc counts edges from raising the request to the answer
  task automatic acc(input logic we, input logic [2:0] m, input logic [31:0] a,
    input logic [31:0] wd);
    cyc = 0;
    seen = 4'h0;
    @(negedge clk);
    sb_req = 1'b1;
    sb_we = we;
    sb_master = m;
    sb_addr = a;
    sb_wdata = wd;
    while (sb_ack !== 1'b1 && sb_err !== 1'b1 && cyc < 2000)
    begin
      @(posedge clk);
      #1;
      cyc++;
      seen = seen | gm_req;
      if (gm_req !== 4'h0)
        {gwe, gseen, wseen} = {gm_we, gm_addr, gm_wdata};
    end
    if (cyc >= 2000)
    begin
      errors++;
      stop_test;
    end
    got_err = sb_err;
    rd = sb_rdata;
    @(negedge clk);
    sb_req = 1'b0;
  endtask
  // Refresh start shows as CAS low with RAS high
  task automatic wait_refr(output time t);
    int n;
    n = 0;
    while (!(ras_n === 1'b1 && cas_n === 1'b0) && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400)
    begin
      errors++;
      stop_test;
    end
    t = $time;
  endtask
  task automatic sync_refr;
    wait_refr(t0);
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_refresh;
    int n;
    wait_refr(t0);
    n = 1;
    @(posedge clk);
    #1;
    while (cas_n === 1'b0 && n < 10)
    begin
      n++;
      @(posedge clk);
      #1;
    end
    chk(n, REFR_BUSY_CYC);
    wait_refr(t1);
    chk((t1 - t0) / CLK_PERIOD_NS, REFR_PERIOD_CYC);
  endtask
  task automatic t_dram;
    sync_refr;
    acc(1'b1, M_EXP, DRAM_BASE + 32'h5, 32'ha5a5_0001);
    chk(cyc, DRAM_WS_MISS + 1);
    acc(1'b1, M_EXP, DRAM_BASE + 32'h6, 32'h3c3c_0002);
    chk(cyc, DRAM_WS_HIT + 1);
    acc(1'b1, M_EXP, DRAM_BASE + 32'h406, 32'h0f0f_0003);
    chk(cyc, DRAM_WS_MISS + 1);
    acc(1'b0, M_EXP, DRAM_BASE + 32'h6, 32'h0);
    chk(rd, 32'h3c3c_0002);
    acc(1'b0, M_EXP, DRAM_BASE + 32'h00ff_ffff, 32'h0);
    chk(got_err, 1'b0);
  endtask
  task automatic t_hold;
    wait_refr(t0);
    acc(1'b0, M_EXP, DRAM_BASE + 32'h6, 32'h0);
    chk(rd, 32'h3c3c_0002);
    chk(32'(cyc > DRAM_WS_MISS + 3), 32'h1);
  endtask
  task automatic t_boot;
    sync_refr;
    acc(1'b0, M_EXP, BOOT_BASE + 32'h10, 32'h0);
    chk(cyc, BOOT_WS + 1);
    chk(rd[31:8], 32'h0);
    repeat (2) @(negedge clk);
  endtask
  task automatic bwr(input logic [16:0] a, input logic [7:0] d);
    acc(1'b1, M_EXP, BOOT_BASE + {15'h0, a}, {24'h0, d});
  endtask
  task automatic brd(input logic [16:0] a);
    acc(1'b0, M_EXP, BOOT_BASE + {15'h0, a}, 32'h0);
    repeat (2) @(negedge clk);
  endtask
  task automatic t_prog;
    bwr(CMD_ADDR1, CMD_D1);
    bwr(CMD_ADDR2, CMD_D2);
    bwr(CMD_ADDR1, CMD_ENABLE);
    bwr(17'h100, 8'h5a);
    bwr(17'h102, 8'h3c);
    repeat (60) @(negedge clk);
    brd(17'h102);
    chk(rd, 32'hbc);
    repeat (300) @(negedge clk);
    brd(17'h102);
    chk(rd, 32'h3c);
    brd(17'h101);
    chk(rd, 32'hff);
    bwr(17'h101, 8'h00);
    repeat (60) @(negedge clk);
    brd(17'h101);
    chk(rd, 32'hff);
  endtask
  task automatic t_node;
    acc(1'b0, M_EXP, 32'h0890_0123, 32'h0);
    chk({gwe, seen}, 5'h02);
    chk(gseen, 32'h8000_0123);
    chk(rd, 32'ha000_0123);
    acc(1'b0, M_VME, VME_BASE_DEFAULT + 32'h0220_0010, 32'h0);
    chk(gseen, 32'h8000_0004);
    chk(rd, 32'h9000_0004);
    acc(1'b1, M_EXP, 32'h08f8_0007, 32'hdead_0007);
    chk({gwe, seen}, 5'h1f);
    chk(wseen, 32'hdead_0007);
    acc(1'b0, M_EXP, 32'h08f8_0007, 32'h0);
    chk(got_err, 1'b1);
    acc(1'b0, M_NODE_A, NODE_MASTER_BASE + 32'h0888_0000, 32'h0);
    chk({seen, got_err}, 5'h01);
    acc(1'b0, M_EXP, 32'h0880_0000, 32'h0);
    chk(got_err, 1'b1);
    gm_fitted = 4'h7;
    repeat (6) @(negedge clk);
    acc(1'b0, M_EXP, 32'h08c0_0000, 32'h0);
    chk({seen, got_err}, 5'h01);
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_refresh;
    t_dram;
    t_hold;
    t_boot;
    t_prog;
    t_node;
    stop_test;
  end
endmodule
